// ### burst_diag_pkg.sv
package burst_diag_pkg;

  // Register window
  localparam int REG_COUNT = 7;
  localparam logic [7:0] OFS_PULSE_NODE = 8'h1F;
  localparam logic [7:0] OFS_LIMIT_ONE = 8'h20;
  localparam logic [7:0] OFS_LIMIT_TWO = 8'h21;
  localparam logic [7:0] OFS_RECORD = 8'h22;
  localparam logic [7:0] OFS_FREQ_WIN = 8'h23;
  localparam logic [7:0] OFS_SAT_FERR = 8'h24;
  localparam logic [7:0] OFS_VOLT_SLEEP = 8'h25;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Writable bits per slot; bit 6 of the first limit register is unused
  localparam logic [7:0] MASK_LIMIT_ONE = 8'hBF;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  // Slot indices inside the window
  localparam logic [2:0] IDX_PULSE_NODE = 3'h0;
  localparam logic [2:0] IDX_LIMIT_ONE = 3'h1;
  localparam logic [2:0] IDX_LIMIT_TWO = 3'h2;
  localparam logic [2:0] IDX_RECORD = 3'h3;
  localparam logic [2:0] IDX_FREQ_WIN = 3'h4;
  localparam logic [2:0] IDX_SAT_FERR = 3'h5;
  localparam logic [2:0] IDX_VOLT_SLEEP = 3'h6;

  // Field positions
  localparam int POS_PULSE_LO = 0;
  localparam int POS_NODE_LO = 5;
  localparam int POS_LIMIT_DIS = 7;
  localparam int POS_CUR_LO = 0;
  localparam int POS_LPF_LO = 6;
  localparam int POS_REC_ONE_LO = 4;
  localparam int POS_REC_TWO_LO = 0;
  localparam int POS_WIN_LO = 4;
  localparam int POS_START_LO = 0;
  localparam int POS_FERR_LO = 5;
  localparam int POS_SAT_LO = 1;
  localparam int POS_NLS_ONE = 0;
  localparam int POS_NLS_TWO = 7;
  localparam int POS_OV_LO = 5;
  localparam int POS_SLEEP_LO = 3;
  localparam int POS_VCHK_LO = 0;

  // Decode constants
  localparam logic [8:0] CUR_BASE_MA = 9'h032;
  localparam logic [8:0] CUR_STEP_MA = 9'h007;
  localparam logic [5:0] WIN_PERIODS_PER_UNIT = 6'h03;
  // Overvoltage thresholds in tenths of a volt
  localparam logic [8:0] OV_DV_0 = 9'h07B;
  localparam logic [8:0] OV_DV_1 = 9'h0B1;
  localparam logic [8:0] OV_DV_2 = 9'h0E4;
  localparam logic [8:0] OV_DV_3 = 9'h11B;

  // Timing
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned START_UNIT_US = 100;
  localparam int unsigned START_UNIT_CYC = START_UNIT_US * CLK_MHZ;
  localparam int unsigned REC_UNIT_US = 4096;
  localparam int unsigned REC_UNIT_CYC = REC_UNIT_US * CLK_MHZ;
  localparam int unsigned SLEEP_MS_0 = 250;
  localparam int unsigned SLEEP_MS_1 = 500;
  localparam int unsigned SLEEP_MS_2 = 1000;
  localparam int unsigned SLEEP_MS_3 = 4000;
  localparam int unsigned SLEEP_CYC_0 = SLEEP_MS_0 * CLK_MHZ * 1000;
  localparam int unsigned SLEEP_CYC_1 = SLEEP_MS_1 * CLK_MHZ * 1000;
  localparam int unsigned SLEEP_CYC_2 = SLEEP_MS_2 * CLK_MHZ * 1000;
  localparam int unsigned SLEEP_CYC_3 = SLEEP_MS_3 * CLK_MHZ * 1000;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [2:0] idx;
    logic hit;
  } slot_t;

  typedef struct packed {
    logic [4:0] second_preset_pulse_count;
    logic second_preset_single_pulse_a;
    logic [2:0] node_address;
    logic current_limit_enable;
    logic [8:0] first_preset_limit_ma;
    logic [8:0] second_preset_limit_ma;
    logic [2:0] lowpass_cutoff_khz;
    logic [5:0] freq_check_window_periods;
    logic freq_check_enable;
    logic [3:0] freq_check_error_limit_us;
    logic [3:0] saturation_level;
    logic first_preset_nonlinear_enable;
    logic second_preset_nonlinear_enable;
    logic [8:0] supply_overvoltage_dv;
    logic [3:0] voltage_check_limit;
  } cfg_t;

endpackage

// ### burst_diag_config_regs.sv
`timescale 1ns/1ps
`default_nettype none

module burst_diag_config_regs
  import burst_diag_pkg::*;
#(
  parameter int unsigned SLEEP_CYC_SEL0 = SLEEP_CYC_0,
  parameter int unsigned SLEEP_CYC_SEL1 = SLEEP_CYC_1,
  parameter int unsigned SLEEP_CYC_SEL2 = SLEEP_CYC_2,
  parameter int unsigned SLEEP_CYC_SEL3 = SLEEP_CYC_3,
  parameter int unsigned REC_UNIT_CYCLES = REC_UNIT_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire bus_req_t bus_in,
  output var logic [7:0] rdata_out,
  input wire logic burst_end_in,
  input wire logic record_start_in,
  input wire logic record_preset_two_in,
  input wire logic activity_in,
  input wire logic sleep_mode_enable_in,
  output var cfg_t cfg_out,
  output var logic freq_check_start_out,
  output var logic record_active_out,
  output var logic sleep_request_out
);

  // Maps a bus address onto a slot of the window
  function automatic slot_t reg_slot(input logic [7:0] a);
    slot_t s;
    logic [7:0] rel;
    rel = a - OFS_PULSE_NODE;
    s.hit = (a >= OFS_PULSE_NODE) && (a <= OFS_VOLT_SLEEP);
    s.idx = rel[2:0];
    return s;
  endfunction

  // Idle time for each sleep select code
  function automatic logic [31:0] sleep_limit(input logic [1:0] sel);
    logic [31:0] v;
    case (sel)
      2'h0: v = SLEEP_CYC_SEL0;
      2'h1: v = SLEEP_CYC_SEL1;
      2'h2: v = SLEEP_CYC_SEL2;
      2'h3: v = SLEEP_CYC_SEL3;
      default: v = SLEEP_CYC_SEL0;
    endcase
    return v;
  endfunction

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [7:0] reg_r [REG_COUNT];
  slot_t wr_slot;
  slot_t rd_slot;
  logic [7:0] read_value;
  cfg_t cfg_nxt;
  logic [15:0] start_cnt_r;
  logic start_armed_r;
  logic [23:0] rec_cnt_r;
  logic [4:0] rec_units;
  logic [31:0] sleep_cnt_r;

  // Reset release through two stages; assertion stays asynchronous
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign wr_slot = reg_slot(bus_in.addr);
  assign rd_slot = reg_slot(bus_in.addr);

  // One flop bank per slot; only writable bits take bus data
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_slot
    localparam logic [7:0] WMASK =
      (g == int'(IDX_LIMIT_ONE)) ? MASK_LIMIT_ONE : MASK_FULL;
    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        reg_r[g] <= REG_RESET;
      end else if (bus_in.wr && wr_slot.hit &&
                   (wr_slot.idx == 3'(g))) begin
        reg_r[g] <= bus_in.wdata & WMASK;
      end
    end
  end

  // Unmapped addresses read back as zero
  always_comb begin
    read_value = 8'h00;
    if (rd_slot.hit) begin
      read_value = reg_r[rd_slot.idx];
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      rdata_out <= read_value;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Field decode into engineering values
  always_comb begin
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] r2;
    logic [7:0] r4;
    logic [7:0] r5;
    logic [7:0] r6;
    r0 = reg_r[IDX_PULSE_NODE];
    r1 = reg_r[IDX_LIMIT_ONE];
    r2 = reg_r[IDX_LIMIT_TWO];
    r4 = reg_r[IDX_FREQ_WIN];
    r5 = reg_r[IDX_SAT_FERR];
    r6 = reg_r[IDX_VOLT_SLEEP];
    cfg_nxt = '0;
    cfg_nxt.second_preset_pulse_count = r0[POS_PULSE_LO +: 5];
    cfg_nxt.second_preset_single_pulse_a = (r0[POS_PULSE_LO +: 5] == 5'h00);
    cfg_nxt.node_address = r0[POS_NODE_LO +: 3];
    cfg_nxt.current_limit_enable = !r1[POS_LIMIT_DIS];
    cfg_nxt.first_preset_limit_ma =
      9'(r1[POS_CUR_LO +: 6]) * CUR_STEP_MA + CUR_BASE_MA;
    cfg_nxt.second_preset_limit_ma =
      9'(r2[POS_CUR_LO +: 6]) * CUR_STEP_MA + CUR_BASE_MA;
    cfg_nxt.lowpass_cutoff_khz = 3'(r2[POS_LPF_LO +: 2]) + 3'h1;
    cfg_nxt.freq_check_window_periods =
      6'(r4[POS_WIN_LO +: 4]) * WIN_PERIODS_PER_UNIT;
    cfg_nxt.freq_check_enable = (r4[POS_WIN_LO +: 4] != 4'h0);
    cfg_nxt.freq_check_error_limit_us = 4'(r5[POS_FERR_LO +: 3]) + 4'h1;
    cfg_nxt.saturation_level = r5[POS_SAT_LO +: 4];
    cfg_nxt.first_preset_nonlinear_enable = r5[POS_NLS_ONE];
    cfg_nxt.second_preset_nonlinear_enable = r6[POS_NLS_TWO];
    case (r6[POS_OV_LO +: 2])
      2'h0: cfg_nxt.supply_overvoltage_dv = OV_DV_0;
      2'h1: cfg_nxt.supply_overvoltage_dv = OV_DV_1;
      2'h2: cfg_nxt.supply_overvoltage_dv = OV_DV_2;
      2'h3: cfg_nxt.supply_overvoltage_dv = OV_DV_3;
      default: cfg_nxt.supply_overvoltage_dv = OV_DV_0;
    endcase
    cfg_nxt.voltage_check_limit = 4'(r6[POS_VCHK_LO +: 3]) + 4'h1;
  end

  // Decoded values are registered so outputs leave straight from flops
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_out <= '0;
    end else begin
      cfg_out <= cfg_nxt;
    end
  end

  // Frequency check start delay, armed by the burst end pulse
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      start_cnt_r <= 16'h0000;
      start_armed_r <= 1'b0;
      freq_check_start_out <= 1'b0;
    end else begin
      freq_check_start_out <= 1'b0;
      if (burst_end_in) begin
        // load delay in 100 us units
        start_cnt_r <= 16'(32'(reg_r[IDX_FREQ_WIN][POS_START_LO +: 4]) *
                           START_UNIT_CYC);
        start_armed_r <= (reg_r[IDX_FREQ_WIN][POS_WIN_LO +: 4] != 4'h0);
      end else if (start_armed_r) begin
        if (start_cnt_r == 16'h0000) begin
          freq_check_start_out <= 1'b1;
          start_armed_r <= 1'b0;
        end else begin
          start_cnt_r <= start_cnt_r - 16'h0001;
        end
      end
    end
  end

  assign rec_units = record_preset_two_in ?
    5'(reg_r[IDX_RECORD][POS_REC_TWO_LO +: 4]) + 5'h01 :
    5'(reg_r[IDX_RECORD][POS_REC_ONE_LO +: 4]) + 5'h01;

  // Record window; a new start restarts it with the current length
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rec_cnt_r <= 24'h000000;
      record_active_out <= 1'b0;
    end else if (record_start_in) begin
      rec_cnt_r <= 24'(32'(rec_units) * REC_UNIT_CYCLES - 32'h1);
      record_active_out <= 1'b1;
    end else if (record_active_out) begin
      if (rec_cnt_r == 24'h000000) begin
        record_active_out <= 1'b0;
      end else begin
        rec_cnt_r <= rec_cnt_r - 24'h000001;
      end
    end
  end

  // Idle timer; any activity or a cleared enable restarts it
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sleep_cnt_r <= 32'h00000000;
      sleep_request_out <= 1'b0;
    end else if (!sleep_mode_enable_in || activity_in) begin
      sleep_cnt_r <= 32'h00000000;
      sleep_request_out <= 1'b0;
    end else if (!sleep_request_out) begin
      if (sleep_cnt_r >=
          sleep_limit(reg_r[IDX_VOLT_SLEEP][POS_SLEEP_LO +: 2]) - 32'h1) begin
        sleep_request_out <= 1'b1;
      end else begin
        sleep_cnt_r <= sleep_cnt_r + 32'h00000001;
      end
    end
  end

  // Checks on the decode and timers
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  // Decode checks skip the release edge, where cfg_out still holds zeros
  a_pulse_count_out: assert property (
    rst_n |=> cfg_out.second_preset_single_pulse_a ==
        ($past(reg_r[IDX_PULSE_NODE][4:0]) == 5'h00))
    else $error("single pulse flag does not follow pulse count");

  a_node_addr_out: assert property (
    bus_in.wr && bus_in.addr == OFS_PULSE_NODE
    |-> ##2 cfg_out.node_address == $past(bus_in.wdata[7:5], 2))
    else $error("node address not taken from write");

  a_limit_disable_bit: assert property (
    reg_r[IDX_LIMIT_ONE][7] |=> !cfg_out.current_limit_enable)
    else $error("current limit still enabled");

  a_first_limit_ma: assert property (
    rst_n |=> cfg_out.first_preset_limit_ma ==
        9'($past(reg_r[IDX_LIMIT_ONE][5:0])) * 9'h007 + 9'h032)
    else $error("preset one limit value wrong");

  a_second_limit_ma: assert property (
    rst_n |=> cfg_out.second_preset_limit_ma ==
        9'($past(reg_r[IDX_LIMIT_TWO][5:0])) * 9'h007 + 9'h032)
    else $error("preset two limit value wrong");

  a_freq_zero_window: assert property (
    burst_end_in && reg_r[IDX_FREQ_WIN][7:4] == 4'h0
    |=> !freq_check_start_out [*3])
    else $error("frequency check started with zero window");

  a_ov_top_code: assert property (
    reg_r[IDX_VOLT_SLEEP][6:5] == 2'h3 |=>
    cfg_out.supply_overvoltage_dv == 9'h11B)
    else $error("overvoltage threshold wrong for top code");

  a_unused_bit_zero: assert property (
    bus_in.rd && bus_in.addr == OFS_LIMIT_ONE |=> !rdata_out[6])
    else $error("unused limit bit reads as one");

  a_sleep_gated: assert property (
    !sleep_mode_enable_in |=> !sleep_request_out)
    else $error("sleep requested while disabled");

  a_read_no_stand: assert property (
    !bus_in.rd |=> rdata_out == 8'h00)
    else $error("read data stands past its cycle");

  a_cutoff_code: assert property (
    rst_n |=> cfg_out.lowpass_cutoff_khz ==
        3'($past(reg_r[IDX_LIMIT_TWO][7:6])) + 3'h1)
    else $error("lowpass cutoff does not follow its code");

  a_volt_limit_code: assert property (
    rst_n |=> cfg_out.voltage_check_limit ==
        4'($past(reg_r[IDX_VOLT_SLEEP][2:0])) + 4'h1)
    else $error("voltage check limit does not follow its code");

  // A lone burst end with zero delay fires on the second edge
  a_start_zero_delay: assert property (
    (burst_end_in && (reg_r[IDX_FREQ_WIN][7:4] != 4'h0) &&
     (reg_r[IDX_FREQ_WIN][3:0] == 4'h0)) ##1 !burst_end_in
    |=> freq_check_start_out)
    else $error("frequency check late after zero delay");

  a_record_starts: assert property (
    record_start_in |=> record_active_out)
    else $error("record window did not open");

  a_sleep_activity: assert property (
    activity_in |=> !sleep_request_out)
    else $error("sleep request survives activity");

  c_write_read: cover property (
    bus_in.wr && bus_in.addr == OFS_SAT_FERR ##1
    bus_in.rd && bus_in.addr == OFS_SAT_FERR);
  c_freq_start: cover property ($rose(freq_check_start_out));
  c_record_end: cover property ($fell(record_active_out));
  c_sleep_req: cover property ($rose(sleep_request_out));

endmodule

`default_nettype wire

// ### burst_diag_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module burst_diag_config_regs_tb_top;
  import burst_diag_pkg::*;
  logic clk_in;
  logic reset_n_in;
  bus_req_t bus_in;
  logic [7:0] rdata_out;
  logic burst_end_in;
  logic record_start_in;
  logic record_preset_two_in;
  logic activity_in;
  logic sleep_mode_enable_in;
  cfg_t cfg_out;
  logic freq_check_start_out;
  logic record_active_out;
  logic sleep_request_out;
  int fails;
  int n_compared;
  logic [7:0] regs [7];
  logic [7:0] exp_q [$];
  logic rd_d;
  logic [7:0] seed;

  // Small counts keep the timer scenarios short
  burst_diag_config_regs #(.SLEEP_CYC_SEL0(20), .SLEEP_CYC_SEL1(40),
    .SLEEP_CYC_SEL2(60), .SLEEP_CYC_SEL3(80), .REC_UNIT_CYCLES(16)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .burst_end_in(burst_end_in),
    .record_start_in(record_start_in),
    .record_preset_two_in(record_preset_two_in), .activity_in(activity_in),
    .sleep_mode_enable_in(sleep_mode_enable_in), .cfg_out(cfg_out),
    .freq_check_start_out(freq_check_start_out),
    .record_active_out(record_active_out),
    .sleep_request_out(sleep_request_out));

  // Clock, 50 ns period
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_cfg(input cfg_t got, input cfg_t exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t cfg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_int(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  // Maximal 8-bit feedback taps
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Decoded settings worked out from the shadow copy
  function automatic cfg_t exp_cfg();
    cfg_t c;
    c.second_preset_pulse_count = regs[0][4:0];
    c.second_preset_single_pulse_a = (regs[0][4:0] == 5'h00);
    c.node_address = regs[0][7:5];
    c.current_limit_enable = ~regs[1][7];
    c.first_preset_limit_ma = 9'(regs[1][5:0]) * 9'h007 + 9'h032;
    c.second_preset_limit_ma = 9'(regs[2][5:0]) * 9'h007 + 9'h032;
    c.lowpass_cutoff_khz = 3'(regs[2][7:6]) + 3'h1;
    c.freq_check_window_periods = 6'(regs[4][7:4]) * 6'h03;
    c.freq_check_enable = (regs[4][7:4] != 4'h0);
    c.freq_check_error_limit_us = 4'(regs[5][7:5]) + 4'h1;
    c.saturation_level = regs[5][4:1];
    c.first_preset_nonlinear_enable = regs[5][0];
    c.second_preset_nonlinear_enable = regs[6][7];
    case (regs[6][6:5])
      2'h0: c.supply_overvoltage_dv = 9'h07B;
      2'h1: c.supply_overvoltage_dv = 9'h0B1;
      2'h2: c.supply_overvoltage_dv = 9'h0E4;
      default: c.supply_overvoltage_dv = 9'h11B;
    endcase
    c.voltage_check_limit = 4'(regs[6][2:0]) + 4'h1;
    return c;
  endfunction

  // One bus cycle; strobes stay until the next call replaces them
  task automatic bus_op(input logic [7:0] a, input logic [7:0] d,
                        input logic w, input logic r);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    if (a >= 8'h1F && a <= 8'h25)
      regs[a - 8'h1F] = (a == 8'h20) ? (d & 8'hBF) : d;
    bus_op(a, d, 1'b1, 1'b0);
  endtask

  task automatic reg_read(input logic [7:0] a);
    exp_q.push_back((a >= 8'h1F && a <= 8'h25) ? regs[a - 8'h1F] : 8'h00);
    bus_op(a, 8'h00, 1'b0, 1'b1);
  endtask

  // Idle the bus, let decode settle, compare the settings
  task automatic settle_cfg();
    bus_op(8'h00, 8'h00, 1'b0, 1'b0);
    repeat (3) @(negedge clk_in);
    check_cfg(cfg_out, exp_cfg());
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_in) rd_d <= bus_in.rd;
  always @(negedge clk_in) begin
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0)
        check_int(1, 0);
      else
        check8(rdata_out, exp_q.pop_front());
    end
  end

  task automatic freq_case(input logic [7:0] code, input int exp_k,
                           input int bound);
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    reg_write(8'h23, code);
    bus_op(8'h00, 8'h00, 1'b0, 1'b0);
    @(posedge clk_in);
    burst_end_in <= 1'b1;
    fork
      begin
        @(posedge clk_in);
        burst_end_in <= 1'b0;
      end
    join_none
    while (!seen && k < bound) begin
      @(negedge clk_in);
      k++;
      seen = (freq_check_start_out === 1'b1);
    end
    check_int(seen ? k : 0, exp_k);
    @(negedge clk_in);
    check8({7'h00, freq_check_start_out}, 8'h00);
  endtask

  task automatic rec_case(input logic [7:0] code, input logic two,
                          input int len);
    int first;
    int cnt;
    first = 0;
    cnt = 0;
    reg_write(8'h22, code);
    bus_op(8'h00, 8'h00, 1'b0, 1'b0);
    @(posedge clk_in);
    record_start_in <= 1'b1;
    record_preset_two_in <= two;
    @(posedge clk_in);
    record_start_in <= 1'b0;
    for (int k = 2; k < len + 40; k++) begin
      @(negedge clk_in);
      if (record_active_out === 1'b1) begin
        if (first == 0)
          first = k;
        cnt++;
      end else if (cnt > 0)
        break;
    end
    check_int(first, 2);
    check_int(cnt, len);
  endtask

  task automatic sleep_case(input logic [1:0] code, input int limit);
    int k;
    k = 0;
    reg_write(8'h25, {3'h0, code, 3'h0});
    bus_op(8'h00, 8'h00, 1'b0, 1'b0);
    @(posedge clk_in);
    sleep_mode_enable_in <= 1'b1;
    while (sleep_request_out !== 1'b1 && k < limit + 10) begin
      @(negedge clk_in);
      k++;
    end
    check_int((k >= limit && k <= limit + 3) ? 1 : 0, 1);
    @(posedge clk_in);
    activity_in <= 1'b1;
    @(posedge clk_in);
    activity_in <= 1'b0;
    @(negedge clk_in);
    check8({7'h00, sleep_request_out}, 8'h00);
    @(posedge clk_in);
    sleep_mode_enable_in <= 1'b0;
  endtask

  // Hang guard
  initial begin
    #4500000;
    fails++;
    report_and_stop();
  end

  initial begin
    int hi;
    bus_in = '0;
    reset_n_in = 1'b0;
    {burst_end_in, record_start_in, record_preset_two_in} = 3'h0;
    {activity_in, sleep_mode_enable_in} = 2'h0;
    fails = 0;
    n_compared = 0;
    seed = 8'h19;
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    // Reset contents and decode of all-zero registers
    for (int i = 0; i < 9; i++) reg_read(8'h1E + 8'(i));
    settle_cfg();
    // Random fill, back-to-back read back
    for (int r = 0; r < 8; r++) begin
      for (int i = 0; i < 7; i++) begin
        seed = lfsr_next(seed);
        reg_write(8'h1F + 8'(i), seed);
      end
      for (int i = 0; i < 7; i++) reg_read(8'h1F + 8'(i));
      settle_cfg();
    end
    // Unused bit, unmapped places
    reg_write(8'h20, 8'hFF);
    reg_write(8'h26, 8'hA5);
    reg_write(8'h1E, 8'h5A);
    reg_read(8'h20);
    reg_read(8'h26);
    reg_read(8'h1E);
    settle_cfg();
    // Every code of the overvoltage, cutoff, error limit and voltage check fields
    for (int k = 0; k < 8; k++) begin
      reg_write(8'h25, {k[0], k[1:0], 2'h0, k[2:0]});
      reg_write(8'h21, {k[1:0], 6'h3F});
      reg_write(8'h24, {k[2:0], k[3:0], k[0]});
      settle_cfg();
    end
    // Frequency check start: zero, one and fifteen units, disabled
    freq_case(8'h10, 3, 60);
    freq_case(8'h11, 2003, 2100);
    freq_case(8'h01, 0, 2100);
    freq_case(8'hFF, 30003, 30100);
    // Record windows per preset
    rec_case(8'h00, 1'b0, 16);
    rec_case(8'hF3, 1'b0, 256);
    rec_case(8'hF3, 1'b1, 64);
    // Without the enable the idle timer never requests sleep
    hi = 0;
    reg_write(8'h25, 8'h00);
    bus_op(8'h00, 8'h00, 1'b0, 1'b0);
    for (int k = 0; k < 100; k++) begin
      @(negedge clk_in);
      if (sleep_request_out !== 1'b0)
        hi++;
    end
    check_int(hi, 0);
    for (int c = 0; c < 4; c++) sleep_case(2'(c), 20 * (c + 1));
    report_and_stop();
  end
endmodule
`default_nettype wire
